// File: hw/cbfls_exec.sv
// Execution core for bit, flag, move and data-memory instructions.
// Assumes a classic Wishbone master and a single 25 MHz clock.
//
// Behaviour
// [RULE1] Rotate right via carry, flags Z C N V
// [RULE2] Arithmetic shift right keeps bit 7
// [RULE3] Copy register bit into bit-copy flag
// [RULE4] Copy bit-copy flag into register bit
// [RULE5] Force one status flag to one or zero
// [RULE6] Register and pair copies, flags untouched
// [RULE7] Pointer read then pointer plus one
// [RULE8] Pointer minus one then read
// [RULE9] Read at Y or Z plus offset
// [RULE10] Read at address from instruction
// [RULE11] Pointer write then pointer plus one
// [RULE12] Pointer minus one then write
// [RULE13] Write at Y plus offset
// [RULE14] Write at Z plus offset
// [RULE15] Write at address from instruction
// [RULE16] Swap register nibbles in one cycle
// [RULE17] Interrupt flag on/off; plain pointer access
// [RULE18] Load constant into register, one cycle
`timescale 1ns/1ps
module cbfls_exec
    import cbfls_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Core status
    output logic busy_o,
    output logic irq_en_o
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = dat[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [4:0] ptr_base(input logic [1:0] p);
        case (p)
            PTR_X: return PTR_X_LO;
            PTR_Y: return PTR_Y_LO;
            default: return PTR_Z_LO;
        endcase
    endfunction

    function automatic logic is_read(input cbfls_op_t o);
        return (o == OP_IND_READ) || (o == OP_DIR_READ);
    endfunction

    function automatic logic is_mem(input cbfls_op_t o);
        return is_read(o) || (o == OP_IND_WRITE) || (o == OP_DIR_WRITE);
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [7:0] regs_q [NREGS];
    logic [7:0] flags_q, flags_d;
    logic [IR_W-1:0] ir_q;
    logic [IMM_W-1:0] imm_q;
    logic ill_q, ack_q, busy_q;
    logic [31:0] dat_q;
    cbfls_state_t state_q, state_d;

    cbfls_mem_if mem_bus ();

    cbfls_dmem u_dmem (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .port (mem_bus.mem)
    );

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    cbfls_op_t op;
    logic [4:0] rd, rr, pb;
    logic [2:0] bidx;
    logic [1:0] ptr, mode;
    logic [7:0] rdv, rrv;
    logic [15:0] pval;
    logic bus_req, bus_wr, start;

    assign op = cbfls_op_t'(ir_q[OP_LSB +: OP_W]);
    assign rd = ir_q[RD_LSB +: IDX_W];
    assign rr = ir_q[RR_LSB +: IDX_W];
    assign bidx = ir_q[BIT_LSB +: BIT_W];
    assign ptr = ir_q[PTR_LSB +: SEL_W];
    assign mode = ir_q[MODE_LSB +: SEL_W];
    assign rdv = regs_q[rd];
    assign rrv = regs_q[rr];
    assign pb = ptr_base(ptr);
    assign pval = {regs_q[pb | 5'h01], regs_q[pb]};
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
    assign bus_wr = bus_req && wb_we_i;
    assign start = bus_wr && (wb_adr_i == ADR_INSTR) && (wb_sel_i != 4'h0);

    // ----------------------------------------------------------------
    // Execute
    // ----------------------------------------------------------------
    logic w0_we, w1_we, ill;
    logic [4:0] w0_a, w1_a;
    logic [7:0] w0_d, w1_d, res;
    logic [15:0] ea, pnew;

    always_comb begin
        w0_we = 1'b0;
        w0_a = rd;
        w0_d = 8'h00;
        w1_we = 1'b0;
        w1_a = rd;
        w1_d = 8'h00;
        flags_d = flags_q;
        ill = 1'b0;
        res = 8'h00;
        ea = pval;
        pnew = pval;
        mem_bus.en = 1'b0;
        mem_bus.we = 1'b0;
        mem_bus.addr = 16'h0000;
        mem_bus.wdata = rrv;
        if (state_q == S_EXEC) begin
            case (op)
                OP_ROT_RC, OP_SHR_ARITH: begin
                    if (op == OP_ROT_RC) begin
                        res = {flags_q[FLAG_C], rdv[7:1]}; // RULE1
                    end else begin
                        res = {rdv[7], rdv[7:1]}; // RULE2
                    end
                    w0_we = 1'b1;
                    w0_d = res;
                    flags_d[FLAG_C] = rdv[0];
                    flags_d[FLAG_Z] = (res == 8'h00);
                    flags_d[FLAG_N] = res[7];
                    flags_d[FLAG_V] = res[7] ^ rdv[0];
                end
                OP_NIB_SWAP: begin
                    w0_we = 1'b1;
                    w0_d = {rdv[3:0], rdv[7:4]}; // RULE16
                end
                OP_FLAG_ONE: flags_d[bidx] = 1'b1; // RULE5
                OP_FLAG_ZERO: flags_d[bidx] = 1'b0; // RULE5
                OP_C_ONE, OP_C_ZERO:
                    flags_d[FLAG_C] = (op == OP_C_ONE); // RULE5
                OP_N_ONE, OP_N_ZERO:
                    flags_d[FLAG_N] = (op == OP_N_ONE); // RULE5
                OP_Z_ONE, OP_Z_ZERO:
                    flags_d[FLAG_Z] = (op == OP_Z_ONE); // RULE5
                OP_S_ONE, OP_S_ZERO:
                    flags_d[FLAG_S] = (op == OP_S_ONE); // RULE5
                OP_V_ONE, OP_V_ZERO:
                    flags_d[FLAG_V] = (op == OP_V_ONE); // RULE5
                OP_T_ONE, OP_T_ZERO:
                    flags_d[FLAG_T] = (op == OP_T_ONE); // RULE5
                OP_H_ONE, OP_H_ZERO:
                    flags_d[FLAG_H] = (op == OP_H_ONE); // RULE5
                OP_IRQ_ON: flags_d[FLAG_I] = 1'b1; // RULE17
                OP_IRQ_OFF: flags_d[FLAG_I] = 1'b0; // RULE17
                OP_BIT_TO_FLAG: flags_d[FLAG_T] = rrv[bidx]; // RULE3
                OP_FLAG_TO_BIT: begin
                    w0_we = 1'b1;
                    w0_d = rdv;
                    w0_d[bidx] = flags_q[FLAG_T]; // RULE4
                end
                OP_REG_COPY: begin
                    w0_we = 1'b1;
                    w0_d = rrv; // RULE6
                end
                OP_PAIR_COPY: begin
                    // Odd indices are rounded down to the even pair
                    w0_we = 1'b1;
                    w0_a = {rd[4:1], 1'b0};
                    w0_d = regs_q[{rr[4:1], 1'b0}]; // RULE6
                    w1_we = 1'b1;
                    w1_a = {rd[4:1], 1'b1};
                    w1_d = regs_q[{rr[4:1], 1'b1}]; // RULE6
                end
                OP_LOAD_IMM: begin
                    w0_we = 1'b1;
                    w0_d = imm_q[7:0]; // RULE18
                end
                OP_IND_READ, OP_IND_WRITE: begin
                    case (mode)
                        MODE_POSTINC: pnew = pval + PTR_STEP; // RULE7 RULE11
                        MODE_PREDEC: begin
                            ea = pval - PTR_STEP; // RULE8 RULE12
                            pnew = ea;
                        end
                        MODE_DISP: ea = pval + imm_q; // RULE9 RULE13 RULE14
                        default: ea = pval; // RULE17
                    endcase
                    // No X pointer with offset and no fourth pointer
                    ill = (ptr > PTR_Z) || (mode == MODE_DISP && ptr == PTR_X);
                    mem_bus.en = !ill;
                    mem_bus.we = (op == OP_IND_WRITE); // RULE11 RULE12
                    mem_bus.addr = ea;
                    if (!ill && mode != MODE_PLAIN && mode != MODE_DISP) begin
                        w0_we = 1'b1;
                        w0_a = pb;
                        w0_d = pnew[7:0];
                        w1_we = 1'b1;
                        w1_a = pb | 5'h01;
                        w1_d = pnew[15:8];
                    end
                end
                OP_DIR_READ, OP_DIR_WRITE: begin
                    mem_bus.en = 1'b1;
                    mem_bus.we = (op == OP_DIR_WRITE); // RULE15
                    mem_bus.addr = imm_q; // RULE10 RULE15
                end
                OP_NOP: ;
                default: ill = 1'b1;
            endcase
        end else if (state_q == S_MEM && is_read(op)) begin
            w0_we = 1'b1;
            w0_d = mem_bus.rdata; // RULE7 RULE8 RULE9 RULE10
        end
    end

    // ----------------------------------------------------------------
    // Sequencer: one cycle, or two for data-memory access
    // ----------------------------------------------------------------
    always_comb begin
        case (state_q)
            S_IDLE: state_d = start ? S_EXEC : S_IDLE;
            S_EXEC: state_d = (is_mem(op) && !ill) ? S_MEM : S_IDLE;
            S_MEM: state_d = S_IDLE;
            default: state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= S_IDLE;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            busy_q <= (state_d != S_IDLE);
        end
    end

    // ----------------------------------------------------------------
    // Register file: execution wins over bus writes
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NREGS; i++) begin
                regs_q[i] <= 8'h00;
            end
        end else if (w0_we || w1_we) begin
            if (w0_we) begin
                regs_q[w0_a] <= w0_d;
            end
            if (w1_we) begin
                regs_q[w1_a] <= w1_d;
            end
        end else if (bus_wr && wb_adr_i[WIN_BIT] && state_q == S_IDLE &&
                     wb_sel_i[0]) begin
            regs_q[wb_adr_i[WIN_IDX_LSB +: IDX_W]] <= wb_dat_i[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Flags: only the bits an instruction names change
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_q <= FLAGS_RST;
        end else if (state_q == S_EXEC) begin
            flags_q <= flags_d;
        end else if (bus_wr && wb_adr_i == ADR_STATUS && wb_sel_i[0] &&
                     state_q == S_IDLE) begin
            flags_q <= wb_dat_i[7:0];
        end
    end

    // ----------------------------------------------------------------
    // Instruction and immediate holding registers
    // ----------------------------------------------------------------
    logic [31:0] ir_mrg, imm_mrg;

    assign ir_mrg = merge(32'(ir_q), wb_dat_i, wb_sel_i);
    assign imm_mrg = merge(32'(imm_q), wb_dat_i, wb_sel_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ir_q <= '0;
            imm_q <= '0;
        end else if (state_q == S_IDLE && bus_wr) begin
            if (start) begin
                ir_q <= ir_mrg[IR_W-1:0];
            end
            if (wb_adr_i == ADR_IMM) begin
                imm_q <= imm_mrg[IMM_W-1:0];
            end
        end
    end

    // Sticky error; a new error in the clearing cycle is kept
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ill_q <= 1'b0;
        end else if (ill || (start && state_q != S_IDLE)) begin
            ill_q <= 1'b1;
        end else if (bus_wr && wb_adr_i == ADR_STATUS && wb_sel_i[1] &&
                     wb_dat_i[STAT_ILL]) begin
            ill_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Wishbone answer: one wait state, unmapped reads give zero
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= bus_req;
            if (bus_req && !wb_we_i) begin
                if (wb_adr_i[WIN_BIT]) begin
                    dat_q <= {24'h000000,
                              regs_q[wb_adr_i[WIN_IDX_LSB +: IDX_W]]};
                end else if (wb_adr_i == ADR_INSTR) begin
                    dat_q <= 32'(ir_q);
                end else if (wb_adr_i == ADR_IMM) begin
                    dat_q <= 32'(imm_q);
                end else if (wb_adr_i == ADR_STATUS) begin
                    dat_q <= 32'({busy_q, ill_q, flags_q});
                end else begin
                    dat_q <= 32'h00000000;
                end
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign busy_o = busy_q;
    assign irq_en_o = flags_q[FLAG_I];

endmodule

// File: shared/cbfls_pkg.sv
// Constants, field layouts and op codes shared by the execution core
// and its data memory. Assumes a 32-bit classic Wishbone register bus.
package cbfls_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADR_INSTR = 8'h00;
    localparam logic [7:0] ADR_IMM = 8'h04;
    localparam logic [7:0] ADR_STATUS = 8'h08;
    localparam int WIN_BIT = 7;
    localparam int WIN_IDX_LSB = 2;

    // ----------------------------------------------------------------
    // Instruction word fields
    // ----------------------------------------------------------------
    localparam int OP_LSB = 0;
    localparam int OP_W = 5;
    localparam int RD_LSB = 5;
    localparam int RR_LSB = 10;
    localparam int IDX_W = 5;
    localparam int BIT_LSB = 15;
    localparam int BIT_W = 3;
    localparam int PTR_LSB = 18;
    localparam int MODE_LSB = 20;
    localparam int SEL_W = 2;
    localparam int IR_W = 22;
    localparam int IMM_W = 16;

    // ----------------------------------------------------------------
    // Status layout and flag positions
    // ----------------------------------------------------------------
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;
    localparam int STAT_ILL = 8;
    localparam int STAT_BUSY = 9;
    localparam logic [7:0] FLAGS_RST = 8'h00;

    // ----------------------------------------------------------------
    // Pointer pairs and addressing modes
    // ----------------------------------------------------------------
    localparam logic [1:0] PTR_X = 2'h0;
    localparam logic [1:0] PTR_Y = 2'h1;
    localparam logic [1:0] PTR_Z = 2'h2;
    localparam logic [4:0] PTR_X_LO = 5'h1A;
    localparam logic [4:0] PTR_Y_LO = 5'h1C;
    localparam logic [4:0] PTR_Z_LO = 5'h1E;
    localparam logic [1:0] MODE_PLAIN = 2'h0;
    localparam logic [1:0] MODE_POSTINC = 2'h1;
    localparam logic [1:0] MODE_PREDEC = 2'h2;
    localparam logic [1:0] MODE_DISP = 2'h3;
    localparam logic [15:0] PTR_STEP = 16'h0001;

    localparam int NREGS = 32;
    localparam int DMEM_AW = 8;
    localparam int DMEM_DEPTH = 256;

    typedef enum logic [4:0] {
        OP_NOP, OP_ROT_RC, OP_SHR_ARITH, OP_NIB_SWAP,
        OP_FLAG_ONE, OP_FLAG_ZERO, OP_BIT_TO_FLAG, OP_FLAG_TO_BIT,
        OP_REG_COPY, OP_PAIR_COPY, OP_LOAD_IMM,
        OP_IND_READ, OP_IND_WRITE, OP_DIR_READ, OP_DIR_WRITE,
        OP_IRQ_ON, OP_IRQ_OFF,
        OP_C_ONE, OP_C_ZERO, OP_N_ONE, OP_N_ZERO, OP_Z_ONE, OP_Z_ZERO,
        OP_S_ONE, OP_S_ZERO, OP_V_ONE, OP_V_ZERO, OP_T_ONE, OP_T_ZERO,
        OP_H_ONE, OP_H_ZERO
    } cbfls_op_t;

    typedef enum logic [1:0] {S_IDLE, S_EXEC, S_MEM} cbfls_state_t;

endpackage

// File: shared/cbfls_mem_if.sv
// Byte-wide port between the execution core and its data memory.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface cbfls_mem_if;
    logic en;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport core (output en, output we, output addr, output wdata,
                  input rdata);
    modport mem (input en, input we, input addr, input wdata,
                 output rdata);
endinterface

// File: hw/cbfls_dmem.sv
// On-chip data memory: synchronous write, registered read.
// Assumes the core holds address and strobes for one clock.
`timescale 1ns/1ps
module cbfls_dmem
    import cbfls_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Core port
    cbfls_mem_if.mem port
);

    logic [7:0] mem_q [DMEM_DEPTH];
    logic [7:0] rdata_q;
    logic [DMEM_AW-1:0] a;

    // Upper address bits are ignored, so addresses wrap on the array
    assign a = port.addr[DMEM_AW-1:0];
    assign port.rdata = rdata_q;

    always_ff @(posedge clk_i) begin
        if (port.en && port.we) begin
            mem_q[a] <= port.wdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= 8'h00;
        end else if (port.en && !port.we) begin
            rdata_q <= mem_q[a];
        end
    end

endmodule

// File: verif/cbfls_exec_assertions.sv
// Checker for the bus and status ports of the execution core.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module cbfls_exec_assertions
    import cbfls_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Status
    input wire logic busy_o,
    input wire logic irq_en_o
);
    logic req;
    logic go;
    logic stw;
    logic legal;
    logic [4:0] op;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign op = wb_dat_i[4:0];
    assign go = req && wb_we_i && wb_adr_i == ADR_INSTR && !busy_o;
    assign stw = wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == ADR_STATUS;
    // Displacement through X or pointer 3 is refused, no access made
    assign legal = wb_dat_i[19:18] != 2'h3 &&
        (wb_dat_i[21:20] != MODE_DISP || wb_dat_i[19:18] != PTR_X);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_answer_a: assert property (req |=> wb_ack_o)
        else $error("no ack after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (!req |=> !wb_ack_o)
        else $error("ack without request");
    one_cycle_a: assert property (
        go && (op < 5'h0B || (op > 5'h0E && op != 5'h1F))
        |=> busy_o ##1 !busy_o) else $error("single-cycle op length");
    mem_cycle_a: assert property (
        go && (op == 5'h0D || op == 5'h0E || (op inside {5'h0B, 5'h0C}
        && legal)) |=> busy_o [*2] ##1 !busy_o)
        else $error("memory op length");
    irq_on_a: assert property (go && op == 5'h0F |-> ##2 irq_en_o)
        else $error("interrupt flag not set");
    irq_off_a: assert property (go && op == 5'h10 |-> ##2 !irq_en_o)
        else $error("interrupt flag not cleared");
    busy_cause_a: assert property ($rose(busy_o) |-> $past(go))
        else $error("busy without instruction");
    irq_cause_a: assert property ($changed(irq_en_o) |->
        $past(busy_o) || $past(stw) || $past(stw, 2) || $past(rst_i))
        else $error("interrupt flag moved on its own");
endmodule

bind cbfls_exec cbfls_exec_assertions u_chk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .busy_o(busy_o),
    .irq_en_o(irq_en_o)
);

// File: verif/cbfls_wb_host.sv
// Classic Wishbone master standing in for the software side.
// Assumes a slave that acks each request exactly once.
`timescale 1ns/1ps
module cbfls_wb_host (
    // Clock
    input wire logic clk_i,
    // Master lines
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o,
    // Slave answer
    input wire logic ack_i,
    input wire logic [31:0] dat_i
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'hFF;
        sel_o = 4'hF;
        dat_o = 32'h0;
    end

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        dat_o <= d;
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = dat_i;
        // Released address and data lines carry junk so stale values are never trusted
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        adr_o <= ~a;
        dat_o <= ~d;
    endtask
endmodule

// File: verif/testbench.sv
// Self-checking bench for the execution core.
// Assumes the core holds its own data memory behind the bus.
`timescale 1ns/1ps
`define CHK(g, e) \
    begin \
        check_count++; \
        if ((g) !== (e)) begin \
            n_errors++; \
            $display("MISMATCH %0t got %h exp %h", $time, g, e); \
        end \
    end
module testbench;
    import cbfls_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc, stb, we, ack, busy, irq;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wd, rdat, v;
    logic [63:0] rw;
    logic [7:0] f;
    int n_errors = 0;
    int check_count = 0;
    localparam int POS [7] = '{0, 2, 1, 4, 3, 6, 5};
    // op, index, imm, dest in, source in, flags in, dest out, flags out
    localparam logic [63:0] ROWS [13] = '{
        64'h0100_0081_0011_C015, 64'h0100_0001_0000_000B,
        64'h0200_0082_0001_C10C, 64'h0200_0001_0000_000B,
        64'h0300_005A_003F_A53F, 64'h0603_0011_0800_1140,
        64'h0603_0011_F7FF_11BF, 64'h0705_0000_0040_2040,
        64'h0701_00FF_0000_FD00, 64'h0800_0000_9C2A_9C2A,
        64'h0A00_7E00_0015_7E15, 64'h0F00_0033_0000_3380,
        64'h1000_0033_00FF_337F};

    always #20 clk_i = ~clk_i;

    cbfls_exec dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .busy_o(busy),
        .irq_en_o(irq));
    cbfls_wb_host host (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb),
        .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd), .ack_i(ack),
        .dat_i(rdat));

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, v);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        host.xfer(1'b0, a, 32'h0, q);
    endtask
    task automatic setr(input int n, input logic [7:0] d);
        wr(8'h80 + 8'(4 * n), {24'h0, d});
    endtask
    task automatic chkr(input int n, input logic [7:0] e);
        rd(8'h80 + 8'(4 * n), v);
        `CHK(v[7:0], e)
    endtask
    task automatic run(input logic [4:0] op, input int d, s,
                       input logic [2:0] b, input logic [1:0] p, m);
        wr(ADR_INSTR, {10'h0, m, p, b, 5'(s), 5'(d), op});
        do rd(ADR_STATUS, v); while (v[STAT_BUSY] === 1'b1);
    endtask
    task automatic report_and_stop;
        $display("Checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        report_and_stop();
    end

    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(ADR_STATUS, v);
        `CHK(v[9:0], 10'h000)
        for (int r = 0; r < 13; r++) begin
            rw = ROWS[r];
            setr(16, rw[39:32]);
            setr(17, rw[31:24]);
            wr(ADR_STATUS, {24'h0, rw[23:16]});
            wr(ADR_IMM, {24'h0, rw[47:40]});
            run(rw[60:56], 16, 17, rw[50:48], PTR_X, MODE_PLAIN);
            chkr(16, rw[15:8]);
            rd(ADR_STATUS, v);
            `CHK(v[7:0], rw[7:0])
            `CHK(irq, rw[7])
        end
        for (int i = 0; i < 8; i++) begin
            wr(ADR_STATUS, 32'h0);
            run(OP_FLAG_ONE, 0, 0, 3'(i), PTR_X, MODE_PLAIN);
            rd(ADR_STATUS, v);
            `CHK(v[7:0], 8'h01 << i)
            wr(ADR_STATUS, 32'hFF);
            run(OP_FLAG_ZERO, 0, 0, 3'(i), PTR_X, MODE_PLAIN);
            rd(ADR_STATUS, v);
            `CHK(v[7:0], ~(8'h01 << i))
        end
        for (int k = 0; k < 14; k++) begin
            f = 8'h01 << POS[k / 2];
            wr(ADR_STATUS, (k % 2) ? 32'h7F : 32'h0);
            run(5'(OP_C_ONE + k), 0, 0, 3'h0, PTR_X, MODE_PLAIN);
            rd(ADR_STATUS, v);
            `CHK(v[7:0], (k % 2) ? (8'h7F & ~f) : f)
        end
        setr(6, 8'h12);
        setr(7, 8'h34);
        run(OP_PAIR_COPY, 2, 6, 3'h0, PTR_X, MODE_PLAIN);
        chkr(2, 8'h12);
        chkr(3, 8'h34);
        // Pointer sequence walks down and up through X
        wr(ADR_STATUS, 32'h2A);
        setr(26, 8'h40);
        setr(27, 8'h00);
        setr(5, 8'hA1);
        setr(7, 8'h3C);
        run(OP_IND_WRITE, 0, 5, 3'h0, PTR_X, MODE_POSTINC);
        chkr(26, 8'h41);
        run(OP_IND_READ, 6, 0, 3'h0, PTR_X, MODE_PREDEC);
        chkr(26, 8'h40);
        chkr(6, 8'hA1);
        run(OP_IND_WRITE, 0, 7, 3'h0, PTR_X, MODE_PREDEC);
        chkr(26, 8'h3F);
        run(OP_IND_READ, 8, 0, 3'h0, PTR_X, MODE_PLAIN);
        chkr(8, 8'h3C);
        chkr(26, 8'h3F);
        run(OP_IND_READ, 9, 0, 3'h0, PTR_X, MODE_POSTINC);
        chkr(9, 8'h3C);
        chkr(26, 8'h40);
        setr(28, 8'h20);
        setr(29, 8'h00);
        wr(ADR_IMM, 32'h5);
        run(OP_IND_WRITE, 0, 5, 3'h0, PTR_Y, MODE_DISP);
        chkr(28, 8'h20);
        setr(30, 8'h30);
        setr(31, 8'h00);
        wr(ADR_IMM, 32'h2);
        run(OP_IND_WRITE, 0, 7, 3'h0, PTR_Z, MODE_DISP);
        chkr(30, 8'h30);
        wr(ADR_IMM, 32'h25);
        run(OP_DIR_READ, 10, 0, 3'h0, PTR_X, MODE_PLAIN);
        chkr(10, 8'hA1);
        wr(ADR_IMM, 32'h12);
        run(OP_IND_READ, 11, 0, 3'h0, PTR_Y, MODE_DISP);
        chkr(11, 8'h3C);
        wr(ADR_IMM, 32'h50);
        run(OP_DIR_WRITE, 0, 6, 3'h0, PTR_X, MODE_PLAIN);
        setr(30, 8'h50);
        run(OP_IND_READ, 12, 0, 3'h0, PTR_Z, MODE_PLAIN);
        chkr(12, 8'hA1);
        // Offset past the top of memory wraps to the low addresses
        wr(ADR_IMM, 32'hE2);
        run(OP_IND_READ, 13, 0, 3'h0, PTR_Z, MODE_DISP);
        chkr(13, 8'h3C);
        rd(ADR_STATUS, v);
        `CHK(v[7:0], 8'h2A)
        run(5'h1F, 0, 0, 3'h0, PTR_X, MODE_PLAIN);
        rd(ADR_STATUS, v);
        `CHK(v[STAT_ILL], 1'b1)
        wr(ADR_STATUS, 32'h100);
        rd(ADR_STATUS, v);
        `CHK(v[STAT_ILL], 1'b0)
        run(OP_IND_READ, 14, 0, 3'h0, PTR_X, MODE_DISP);
        rd(ADR_STATUS, v);
        `CHK(v[STAT_ILL], 1'b1)
        chkr(14, 8'h00);
        rd(8'h40, v);
        `CHK(v, 32'h0)
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        chkr(5, 8'h00);
        rd(ADR_STATUS, v);
        `CHK(v[9:0], 10'h000)
        `CHK(irq, 1'b0)
        report_and_stop();
    end
endmodule
